// ==== hw/afb_alu.sv ====
// Purpose: 8-bit ALU with condition flags, banked register file and bank swap.
// Assumes: One instruction at a time from the sequencer; core_clk_i period is one T-state.
// Notes:   Registers reached over Avalon-MM with waitrequest.
// How it works
// - Forty-four registers; twenty-four form main and alternate banks for A and B.
// - Bank swap picks active banks; unselected banks keep their contents.
// - Bank swap may optionally set or clear the global interrupt gate.
// - Eight-bit ALU with arithmetic, logic, rotate and shift on any register.
// - Register-destination instructions take two T-states.
// - Memory-destination instructions take three T-states.
// - Add with and without carry, subtract with and without borrow in carry.
// - Subtraction adds the two's complement of the subtrahend.
// - Logic set: complement, AND, OR, XOR, compare and bit test.
// - Shift left or right, rotate right, by zero to seven bits.
// - Shifts and rotates work on one register only, never memory.
// - Negative flag follows result bit 7 when affected.
// - Carry set on addition carry out or subtraction borrow.
// - Shift and rotate carry is the last bit out; otherwise cleared.
// - Overflow set when the signed arithmetic result does not fit.
// - Zero flag set only for an all-zero result.
// - Flags not affected by an instruction keep their value.
// - Software reads and writes all four flags through the flag register.
// - Flags are saved on interrupt or call and restored on return.
// - Flags are computed alongside the result at no extra T-state.
// - Chained add and subtract feed the carry flag in.
// - Compare uses a register against an immediate.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "afb_regs.svh"

module afb_alu (
	input  logic              core_clk_i,
	input  logic              rst_n_i,
	input  logic [3:0]        avs_address_i,
	input  logic              avs_read_i,
	input  logic              avs_write_i,
	input  logic [31:0]       avs_writedata_i,
	input  logic [3:0]        avs_byteenable_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	input  logic              instr_valid_i,
	output logic              instr_ready_o,
	input  afb_pkg::afb_op_t  instr_op_i,
	input  logic [4:0]        instr_dst_i,
	input  logic [4:0]        instr_src_i,
	input  logic [7:0]        instr_imm_i,
	input  logic              instr_use_imm_i,
	input  logic              instr_mem_i,
	input  logic [2:0]        instr_amt_i,
	input  logic [1:0]        instr_bank_i,
	input  logic [1:0]        instr_gate_i,
	output logic              instr_done_o,
	output logic [7:0]        result_o,
	output logic              mem_wr_o,
	output logic [7:0]        mem_data_o,
	output logic [3:0]        flags_o,
	output logic [1:0]        bank_sel_o,
	output logic              global_irq_gate_o,
	input  logic              ctx_save_i,
	output logic              ctx_save_o,
	output logic [6:0]        ctx_word_o,
	input  logic              ctx_restore_i,
	input  logic [6:0]        ctx_word_i
);

	afb_pkg::afb_st_t s_q;
	afb_pkg::afb_st_t s_d;
	logic             bus_req;
	logic             be0_wr;
	logic [8:0]       sum9;
	logic [8:0]       sh9;
	logic [15:0]      rot;
	logic [7:0]       res;
	logic             c_n;
	logic             v_n;
	logic             aff_nz;
	logic             aff_c;
	logic             aff_v;
	logic             wr_reg;
	logic [3:0]       wd_flags;

	// ==========================================================================
	// Visible index to physical register: 0-5 bank A, 6-11 bank B, 12-31 unbanked.
	function automatic logic [5:0] phys(input logic [4:0] idx, input logic alt_a, input logic alt_b);
		logic [5:0] p;
		p = {1'b0, idx};
		if (p < `AFB_BANK_REGS)
			p = p + (alt_a ? `AFB_BANK_REGS : 6'h00);
		else if (p < `AFB_BANKED_REGS)
			p = p + (alt_b ? `AFB_BANKED_REGS : `AFB_BANK_REGS);
		else
			p = p + `AFB_BANKED_REGS;
		return p;
	endfunction

	// ==========================================================================
	// Combinational outputs of the handshakes.
	assign bus_req           = avs_read_i | avs_write_i;
	assign be0_wr            = avs_write_i & s_q.ack & avs_byteenable_i[0];
	assign wd_flags          = avs_writedata_i[3:0];
	assign avs_waitrequest_o = bus_req & ~s_q.ack;
	assign instr_ready_o     = (s_q.st == afb_pkg::AFB_ST_T1);
	assign instr_done_o      = (s_q.st == afb_pkg::AFB_ST_T2);
	assign mem_wr_o          = (s_q.st == afb_pkg::AFB_ST_T2) & s_q.mem;
	assign avs_readdata_o    = s_q.rdata;
	assign result_o          = s_q.res;
	assign mem_data_o        = s_q.mem_data;
	assign flags_o           = s_q.flg;
	assign bank_sel_o        = {s_q.bank_b, s_q.bank_a};
	assign global_irq_gate_o = s_q.global_irq_gate;
	assign ctx_save_o        = s_q.ctx_save;
	assign ctx_word_o        = s_q.ctx_word;

	// ==========================================================================
	// Result and flag terms are formed from the latched operands in one pass, so
	// the flags are ready in the same T-state as the result.
	always_comb
	begin
		sum9   = 9'h000;
		sh9    = 9'h000;
		rot    = 16'h0000;
		res    = 8'h00;
		c_n    = 1'b0;
		v_n    = 1'b0;
		aff_nz = 1'b1;
		aff_c  = 1'b0;
		aff_v  = 1'b0;
		wr_reg = 1'b1;
		unique case (s_q.op)
			afb_pkg::AFB_OP_ADD, afb_pkg::AFB_OP_CSUM:
			begin
				sum9  = {1'b0, s_q.a} + {1'b0, s_q.b}
					+ {8'h00, (s_q.op == afb_pkg::AFB_OP_CSUM) & s_q.flg[`AFB_FLG_C]};
				res   = sum9[7:0];
				c_n   = sum9[8];
				v_n   = (s_q.a[7] == s_q.b[7]) & (res[7] != s_q.a[7]);
				aff_c = 1'b1;
				aff_v = 1'b1;
			end
			afb_pkg::AFB_OP_SUB, afb_pkg::AFB_OP_BDIFF, afb_pkg::AFB_OP_CMP:
			begin
				// Borrow-in of one means add no extra one to the complement.
				sum9   = {1'b0, s_q.a} + {1'b0, ~s_q.b}
					+ {8'h00, ~((s_q.op == afb_pkg::AFB_OP_BDIFF) & s_q.flg[`AFB_FLG_C])};
				res    = sum9[7:0];
				c_n    = ~sum9[8];
				v_n    = (s_q.a[7] != s_q.b[7]) & (res[7] != s_q.a[7]);
				aff_c  = 1'b1;
				aff_v  = 1'b1;
				wr_reg = (s_q.op != afb_pkg::AFB_OP_CMP);
			end
			afb_pkg::AFB_OP_CPL:
				res = ~s_q.a;
			afb_pkg::AFB_OP_AND:
				res = s_q.a & s_q.b;
			afb_pkg::AFB_OP_OR:
				res = s_q.a | s_q.b;
			afb_pkg::AFB_OP_XOR:
				res = s_q.a ^ s_q.b;
			afb_pkg::AFB_OP_MOVE:
				res = s_q.a;
			afb_pkg::AFB_OP_BIT:
			begin
				res    = s_q.a & s_q.b;
				wr_reg = 1'b0;
			end
			afb_pkg::AFB_OP_SHL:
			begin
				sh9   = {1'b0, s_q.a} << s_q.amt;
				res   = sh9[7:0];
				c_n   = sh9[8];
				aff_c = 1'b1;
			end
			afb_pkg::AFB_OP_SHR:
			begin
				sh9   = {s_q.a, 1'b0} >> s_q.amt;
				res   = sh9[8:1];
				c_n   = sh9[0];
				aff_c = 1'b1;
			end
			afb_pkg::AFB_OP_ROR:
			begin
				rot   = {s_q.a, s_q.a} >> s_q.amt;
				res   = rot[7:0];
				c_n   = (s_q.amt != 3'h0) & res[7];
				aff_c = 1'b1;
			end
			afb_pkg::AFB_OP_SWAP:
			begin
				aff_nz = 1'b0;
				wr_reg = 1'b0;
			end
			default:
			begin
				aff_nz = 1'b0;
				wr_reg = 1'b0;
			end
		endcase
	end

	// ==========================================================================
	// Next state: bus writes first, then the instruction commit, then a restore,
	// so hardware events win over a coincident software write.
	always_comb
	begin
		s_d          = s_q;
		s_d.ack      = bus_req & ~s_q.ack;
		s_d.ctx_save = ctx_save_i;
		if (bus_req & ~s_q.ack & avs_read_i)
		begin
			unique case (avs_address_i)
				`AFB_OFS_FLAGS: s_d.rdata = {28'h000_0000, s_q.flg};
				`AFB_OFS_CTRL:  s_d.rdata = {29'h000_0000, s_q.global_irq_gate, s_q.bank_b, s_q.bank_a};
				`AFB_OFS_STAT:  s_d.rdata = {30'h000_0000, s_q.st};
				default:        s_d.rdata = 32'h0000_0000;
			endcase
		end
		if (be0_wr & (avs_address_i == `AFB_OFS_FLAGS))
			s_d.flg = wd_flags;
		if (be0_wr & (avs_address_i == `AFB_OFS_CTRL))
		begin
			s_d.bank_a = avs_writedata_i[`AFB_CTRL_BANK_A];
			s_d.bank_b = avs_writedata_i[`AFB_CTRL_BANK_B];
			s_d.global_irq_gate    = avs_writedata_i[`AFB_CTRL_GATE];
		end
		// Context word keeps the values in force before this edge.
		if (ctx_save_i)
			s_d.ctx_word = {s_q.global_irq_gate, s_q.bank_b, s_q.bank_a, s_q.flg};
		unique case (s_q.st)
			afb_pkg::AFB_ST_T1:
			begin
				if (instr_valid_i)
				begin
					s_d.op    = instr_op_i;
					s_d.amt   = instr_amt_i;
					s_d.xbank = instr_bank_i;
					s_d.xgate = instr_gate_i;
					s_d.dphys = phys(instr_dst_i, s_q.bank_a, s_q.bank_b);
					s_d.a     = s_q.rf[phys(instr_src_i, s_q.bank_a, s_q.bank_b)];
					s_d.b     = (instr_use_imm_i | (instr_op_i == afb_pkg::AFB_OP_CMP))
						? instr_imm_i : s_q.rf[s_d.dphys];
					s_d.mem   = instr_mem_i;
					if ((instr_op_i == afb_pkg::AFB_OP_SHL) | (instr_op_i == afb_pkg::AFB_OP_SHR)
						| (instr_op_i == afb_pkg::AFB_OP_ROR))
					begin
						s_d.a   = s_q.rf[s_d.dphys];
						s_d.mem = 1'b0;
					end
					if ((instr_op_i == afb_pkg::AFB_OP_CMP) | (instr_op_i == afb_pkg::AFB_OP_BIT)
						| (instr_op_i == afb_pkg::AFB_OP_SWAP))
						s_d.mem = 1'b0;
					s_d.st = s_d.mem ? afb_pkg::AFB_ST_TX : afb_pkg::AFB_ST_T2;
				end
			end
			afb_pkg::AFB_ST_TX:
			begin
				s_d.mem_data = res;
				s_d.st       = afb_pkg::AFB_ST_T2;
			end
			afb_pkg::AFB_ST_T2:
			begin
				s_d.res = res;
				if (wr_reg & ~s_q.mem)
					s_d.rf[s_q.dphys] = res;
				// Flags commit in the same edge as the result.
				if (aff_nz)
				begin
					s_d.flg[`AFB_FLG_N] = res[7];
					s_d.flg[`AFB_FLG_Z] = (res == 8'h00);
				end
				if (aff_c)
					s_d.flg[`AFB_FLG_C] = c_n;
				if (aff_v)
					s_d.flg[`AFB_FLG_V] = v_n;
				if (s_q.op == afb_pkg::AFB_OP_SWAP)
				begin
					s_d.bank_a = s_q.xbank[0];
					s_d.bank_b = s_q.xbank[1];
					if (s_q.xgate == `AFB_GATE_SET)
						s_d.global_irq_gate = 1'b1;
					else if (s_q.xgate == `AFB_GATE_CLEAR)
						s_d.global_irq_gate = 1'b0;
				end
				s_d.st = afb_pkg::AFB_ST_T1;
			end
			default:
				s_d.st = afb_pkg::AFB_ST_T1;
		endcase
		if (ctx_restore_i)
		begin
			s_d.flg    = ctx_word_i[3:0];
			s_d.bank_a = ctx_word_i[4];
			s_d.bank_b = ctx_word_i[5];
		end
	end

	// ==========================================================================
	// State register.
	always_ff @(posedge core_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_q        <= '0;
			s_q.flg    <= `AFB_RST_FLAGS;
			s_q.bank_a <= `AFB_RST_BANK;
			s_q.bank_b <= `AFB_RST_BANK;
			s_q.global_irq_gate    <= `AFB_RST_GATE;
		end
		else
			s_q <= s_d;
	end

	// ==========================================================================
	// Checks.
	default clocking afb_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic take_reg;
	logic take_mem;
	logic nz_commit;
	logic bank_hold;
	assign take_reg  = instr_ready_o & instr_valid_i & ~s_d.mem;
	assign take_mem  = instr_ready_o & instr_valid_i & s_d.mem;
	assign nz_commit = instr_done_o & aff_nz & ~ctx_restore_i;
	assign bank_hold = ~(instr_done_o & (s_q.op == afb_pkg::AFB_OP_SWAP)) & ~ctx_restore_i
		& ~(be0_wr & (avs_address_i == `AFB_OFS_CTRL));

	sequence afb_seq_tx;
		!instr_done_o & !mem_wr_o;
	endsequence
	sequence afb_seq_t2_mem;
		instr_done_o & mem_wr_o;
	endsequence

	AST_TWO_TSTATES: assert property (take_reg |=> instr_done_o & !mem_wr_o ##1 instr_ready_o)
		else $error("register instruction did not finish in two T-states");
	AST_THREE_TSTATES: assert property (take_mem |=> afb_seq_tx ##1 afb_seq_t2_mem)
		else $error("memory instruction did not finish in three T-states");
	AST_NEG_FLAG: assert property (nz_commit |=> flags_o[`AFB_FLG_N] == result_o[7])
		else $error("negative flag does not follow result bit 7");
	AST_ZERO_FLAG: assert property (nz_commit |=> flags_o[`AFB_FLG_Z] == (result_o == 8'h00))
		else $error("zero flag does not match result");
	AST_V_KEPT: assert property (instr_done_o & !aff_v & !ctx_restore_i & !be0_wr
		|=> $stable(flags_o[`AFB_FLG_V]))
		else $error("overflow flag changed by an instruction that does not affect it");
	AST_NO_WRITEBACK: assert property (instr_done_o & !wr_reg |=> $stable(s_q.rf))
		else $error("compare or bit test wrote a register");
	AST_BANK_KEPT: assert property (bank_hold |=> $stable(bank_sel_o))
		else $error("bank selection changed without a swap");
	// A shift that kept its memory request would pass through TX and miss done here.
	AST_SHIFT_NO_MEM: assert property (instr_ready_o & instr_valid_i & ((instr_op_i == afb_pkg::AFB_OP_SHL)
		| (instr_op_i == afb_pkg::AFB_OP_SHR) | (instr_op_i == afb_pkg::AFB_OP_ROR)) |=> instr_done_o & !mem_wr_o)
		else $error("shift or rotate went to data memory");
	AST_FLAG_WRITE: assert property (be0_wr & (avs_address_i == `AFB_OFS_FLAGS) & !instr_done_o & !ctx_restore_i
		|=> flags_o == $past(wd_flags))
		else $error("software flag write not stored");
	AST_RESTORE: assert property (ctx_restore_i |=> flags_o == $past(ctx_word_i[3:0]))
		else $error("flags not restored from stack word");

endmodule // afb_alu

// ==== hw/afb_regs.svh ====
// Purpose: Offsets, field positions and reset values of the ALU flag and bank block.
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only; include by bare name.
`ifndef AFB_REGS_SVH
`define AFB_REGS_SVH

// ==========================================================================
// Register offsets
`define AFB_OFS_FLAGS    4'h0
`define AFB_OFS_CTRL     4'h4
`define AFB_OFS_STAT     4'h8

// ==========================================================================
// Field positions
`define AFB_FLG_Z        0
`define AFB_FLG_V        1
`define AFB_FLG_C        2
`define AFB_FLG_N        3
`define AFB_CTRL_BANK_A  0
`define AFB_CTRL_BANK_B  1
`define AFB_CTRL_GATE    2

// ==========================================================================
// Reset values and register file shape
`define AFB_RST_FLAGS    4'h0
`define AFB_RST_BANK     1'b0
`define AFB_RST_GATE     1'b0
`define AFB_BANK_REGS    6'h06
`define AFB_BANKED_REGS  6'h0c
`define AFB_GATE_SET     2'b10
`define AFB_GATE_CLEAR   2'b11

`endif

// ==== hw/afb_pkg.sv ====
// Purpose: Types of the ALU flag and bank block.
// Assumes: Used with afb_regs.svh for all numeric constants.
// Notes:   Nothing here is imported; users write afb_pkg::name.
package afb_pkg;

	// ==========================================================================
	// Instruction phases, one per T-state.
	typedef enum logic [1:0] {
		AFB_ST_T1 = 2'b00,
		AFB_ST_TX = 2'b01,
		AFB_ST_T2 = 2'b10
	} afb_state_t;

	// ==========================================================================
	// Operation codes.
	typedef enum logic [3:0] {
		AFB_OP_ADD   = 4'b0000,
		AFB_OP_CSUM  = 4'b0001,
		AFB_OP_SUB   = 4'b0010,
		AFB_OP_BDIFF = 4'b0011,
		AFB_OP_CMP   = 4'b0100,
		AFB_OP_CPL   = 4'b0101,
		AFB_OP_AND   = 4'b0110,
		AFB_OP_OR    = 4'b0111,
		AFB_OP_XOR   = 4'b1000,
		AFB_OP_BIT   = 4'b1001,
		AFB_OP_SHL   = 4'b1010,
		AFB_OP_SHR   = 4'b1011,
		AFB_OP_ROR   = 4'b1100,
		AFB_OP_SWAP  = 4'b1101,
		AFB_OP_MOVE  = 4'b1110
	} afb_op_t;

	// ==========================================================================
	// Whole state of the block.
	typedef struct packed {
		afb_state_t        st;
		logic [43:0][7:0]  rf;
		logic [3:0]        flg;
		logic              bank_a;
		logic              bank_b;
		logic              global_irq_gate;
		afb_op_t           op;
		logic [7:0]        a;
		logic [7:0]        b;
		logic [5:0]        dphys;
		logic              mem;
		logic [2:0]        amt;
		logic [1:0]        xbank;
		logic [1:0]        xgate;
		logic [7:0]        res;
		logic [7:0]        mem_data;
		logic              ack;
		logic [31:0]       rdata;
		logic [6:0]        ctx_word;
		logic              ctx_save;
	} afb_st_t;

endpackage

// ==== verif/afb_alu_tb_top.sv ====
// Purpose: Self-checking bench for the ALU flag and bank block.
// Assumes: One bus access or instruction in flight at a time; register 31 stays zero.
// Notes:   Reset and register reads first, then the table of ALU cases, then bus, timing, bank and context cases.
`timescale 1ns/100ps
`include "afb_regs.svh"

module afb_alu_tb_top;

	// ==========================================================================
	// Stimulus, observed outputs and bookkeeping
	typedef struct packed {
		afb_pkg::afb_op_t op;
		logic [7:0]       a;
		logic [7:0]       b;
		logic             u;
		logic [2:0]       n;
		logic [3:0]       f;
	} afb_row_t;

	logic             clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, iv = 1'b0, ui = 1'b0, im = 1'b0;
	logic             cs = 1'b0, cr = 1'b0, mw, wreq, rdy, done, mwr, global_irq_gate, cso;
	logic [3:0]       addr = 4'h0, be = 4'h0, flg;
	logic [31:0]      wdata = 32'h0000_0000, rdata, q;
	afb_pkg::afb_op_t op = afb_pkg::AFB_OP_ADD;
	logic [4:0]       dst = 5'h00, src = 5'h00;
	logic [7:0]       imm = 8'h00, res, mdat, md;
	logic [2:0]       amt = 3'h0;
	logic [1:0]       bank = 2'h0, gate = 2'h0, bsel;
	logic [6:0]       cw = 7'h00, cwo;
	logic [11:0]      e;
	int               fail_count = 0, n_tests = 0, lat;

	// Ordinary cases; the flag column is written to the flag register first.
	afb_row_t rows [20] = '{
		'{afb_pkg::AFB_OP_ADD,   8'hea, 8'h8c, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_ADD,   8'h7f, 8'h01, 1'b1, 3'h0, 4'hf},
		'{afb_pkg::AFB_OP_CSUM,  8'h10, 8'h20, 1'b1, 3'h0, 4'h4},
		'{afb_pkg::AFB_OP_CSUM,  8'hff, 8'h00, 1'b1, 3'h0, 4'h4},
		'{afb_pkg::AFB_OP_SUB,   8'hba, 8'hc4, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_SUB,   8'h80, 8'h01, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_BDIFF, 8'h05, 8'h05, 1'b1, 3'h0, 4'h4},
		'{afb_pkg::AFB_OP_CMP,   8'h33, 8'h33, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_CMP,   8'h10, 8'h20, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_CPL,   8'h5a, 8'h00, 1'b0, 3'h0, 4'h6},
		'{afb_pkg::AFB_OP_AND,   8'hf0, 8'h3c, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_OR,    8'h00, 8'h00, 1'b1, 3'h0, 4'h2},
		'{afb_pkg::AFB_OP_XOR,   8'hff, 8'h0f, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_BIT,   8'h81, 8'h80, 1'b1, 3'h0, 4'h0},
		'{afb_pkg::AFB_OP_SHL,   8'h81, 8'h00, 1'b1, 3'h1, 4'h0},
		'{afb_pkg::AFB_OP_SHL,   8'h81, 8'h00, 1'b1, 3'h0, 4'h4},
		'{afb_pkg::AFB_OP_SHR,   8'h81, 8'h00, 1'b1, 3'h1, 4'h0},
		'{afb_pkg::AFB_OP_SHR,   8'h80, 8'h00, 1'b1, 3'h7, 4'h0},
		'{afb_pkg::AFB_OP_ROR,   8'h01, 8'h00, 1'b1, 3'h1, 4'h0},
		'{afb_pkg::AFB_OP_ROR,   8'h81, 8'h00, 1'b1, 3'h7, 4'h4}
	};

	// ==========================================================================
	// Clock and device under test
	// A 20 ns period gives one T-state per cycle.
	always #10 clk = ~clk;

	afb_alu afb_alu_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.instr_valid_i(iv), .instr_ready_o(rdy), .instr_op_i(op), .instr_dst_i(dst), .instr_src_i(src),
		.instr_imm_i(imm), .instr_use_imm_i(ui), .instr_mem_i(im), .instr_amt_i(amt), .instr_bank_i(bank),
		.instr_gate_i(gate), .instr_done_o(done), .result_o(res), .mem_wr_o(mwr), .mem_data_o(mdat),
		.flags_o(flg), .bank_sel_o(bsel), .global_irq_gate_o(global_irq_gate), .ctx_save_i(cs), .ctx_save_o(cso),
		.ctx_word_o(cwo), .ctx_restore_i(cr), .ctx_word_i(cw)
	);

	// ==========================================================================
	// Reference model, checks and bus tasks
	// Returns {result, N, C, V, Z}; flags that the operation leaves alone come from f.
	function automatic logic [11:0] model(afb_pkg::afb_op_t o, logic [7:0] a, logic [7:0] b, logic [2:0] n,
		logic [3:0] f);
		logic [8:0] s;
		logic [7:0] r;
		logic       c;
		logic       v;
		c = f[2];
		v = f[1];
		s = 9'h000;
		r = 8'h00;
		case (o)
			afb_pkg::AFB_OP_ADD, afb_pkg::AFB_OP_CSUM:
			begin
				s = {1'b0, a} + {1'b0, b} + {8'h00, (o == afb_pkg::AFB_OP_CSUM) & f[2]};
				r = s[7:0];
				c = s[8];
				v = (a[7] == b[7]) && (r[7] != a[7]);
			end
			afb_pkg::AFB_OP_SUB, afb_pkg::AFB_OP_BDIFF, afb_pkg::AFB_OP_CMP:
			begin
				s = {1'b0, a} - {1'b0, b} - {8'h00, (o == afb_pkg::AFB_OP_BDIFF) & f[2]};
				r = s[7:0];
				c = s[8];
				v = (a[7] != b[7]) && (r[7] != a[7]);
			end
			afb_pkg::AFB_OP_CPL: r = ~a;
			afb_pkg::AFB_OP_AND, afb_pkg::AFB_OP_BIT: r = a & b;
			afb_pkg::AFB_OP_OR: r = a | b;
			afb_pkg::AFB_OP_XOR: r = a ^ b;
			afb_pkg::AFB_OP_SHL:
			begin
				r = a << n;
				c = (n != 3'h0) && a[8 - n];
			end
			afb_pkg::AFB_OP_SHR:
			begin
				r = a >> n;
				c = (n != 3'h0) && a[n - 1];
			end
			afb_pkg::AFB_OP_ROR:
			begin
				r = (a >> n) | (a << (8 - n));
				c = (n != 3'h0) && r[7];
			end
			default: r = 8'h00;
		endcase
		return {r, r[7], c, v, r == 8'h00};
	endfunction

	// Case equality keeps an unknown from passing as a match.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until waitrequest is sampled low, then releases it.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] en);
		int          n;
		logic        ok;
		logic [31:0] sd;
		n = 0;
		@(posedge clk);
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		be <= en;
		// Look at the settled answer inside the cycle, then let the edge that takes it pass.
		do
		begin
			#1;
			ok = (wreq === 1'b0);
			sd = rdata;
			@(posedge clk);
			n++;
		end
		while (!ok && n < 20);
		if (!ok)
			fail_count++;
		q = sd;
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
	endtask

	// Offers one instruction, measures cycles from take to done, returns after the commit edge.
	task automatic exec(input afb_pkg::afb_op_t o, input logic [4:0] d, input logic [4:0] s, input logic [7:0] i,
		input logic u, input logic m, input logic [2:0] n, input logic [1:0] bk, input logic [1:0] g);
		int   k;
		logic ok;
		@(posedge clk);
		iv <= 1'b1;
		op <= o;
		dst <= d;
		src <= s;
		imm <= i;
		ui <= u;
		im <= m;
		amt <= n;
		bank <= bk;
		gate <= g;
		k = 0;
		// Ready is judged settled inside the cycle, so the take edge is known exactly.
		do
		begin
			#1;
			ok = (rdy === 1'b1);
			@(posedge clk);
			k++;
		end
		while (!ok && k < 20);
		if (!ok)
			fail_count++;
		iv <= 1'b0;
		lat = 0;
		mw = 1'b0;
		md = 8'h00;
		for (k = 0; k < 10; k++)
		begin
			#1;
			lat++;
			if (done === 1'b1)
			begin
				mw = mwr;
				md = mdat;
				break;
			end
			@(posedge clk);
		end
		@(posedge clk);
		#1;
	endtask

	// Register load goes through OR with zero register 31; read-back through OR into scratch 30.
	task automatic ld(input logic [4:0] r, input logic [7:0] v);
		exec(afb_pkg::AFB_OP_OR, r, 5'h1f, v, 1'b1, 1'b0, 3'h0, 2'h0, 2'h0);
	endtask

	task automatic getr(input logic [4:0] r);
		exec(afb_pkg::AFB_OP_OR, 5'h1e, r, 8'h00, 1'b1, 1'b0, 3'h0, 2'h0, 2'h0);
	endtask

	task automatic stop_test;
		$display("Counts: %0d mismatches in %0d comparisons", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ==========================================================================
	// Watchdog: the whole sequence needs well under 3,000 cycles, so 10,000 means a hang.
	initial
	begin
		#200000;
		fail_count++;
		stop_test;
	end

	// ==========================================================================
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(flg, 4'h0);
		chk({bsel, global_irq_gate, rdy}, 4'h1);
		bus(1'b0, `AFB_OFS_FLAGS, 32'h0000_0000, 4'hf); chk(q, 32'h0000_0000);
		bus(1'b0, `AFB_OFS_STAT, 32'h0000_0000, 4'hf); chk(q, 32'h0000_0000);
		bus(1'b0, 4'hc, 32'h0000_0000, 4'hf); chk(q, 32'h0000_0000);
		// Table rows: source and destination both preloaded with the first operand.
		foreach (rows[i])
		begin
			ld(5'h01, rows[i].a);
			ld(5'h02, rows[i].a);
			bus(1'b1, `AFB_OFS_FLAGS, {28'h000_0000, rows[i].f}, 4'hf);
			exec(rows[i].op, 5'h02, 5'h01, rows[i].b, rows[i].u, 1'b0, rows[i].n, 2'h0, 2'h0);
			e = model(rows[i].op, rows[i].a, rows[i].u ? rows[i].b : rows[i].a, rows[i].n, rows[i].f);
			chk(res, e[11:4]);
			chk(flg, e[3:0]);
			chk(lat, 1);
			getr(5'h02);
			chk(res, (rows[i].op inside {afb_pkg::AFB_OP_CMP, afb_pkg::AFB_OP_BIT}) ? rows[i].a : e[11:4]);
		end
		// Flag and control register access, with a flag write whose byte enable is off.
		bus(1'b1, `AFB_OFS_FLAGS, 32'h0000_0005, 4'hf);
		bus(1'b1, `AFB_OFS_FLAGS, 32'h0000_000f, 4'h0);
		bus(1'b0, `AFB_OFS_FLAGS, 32'h0000_0000, 4'hf); chk(q, 32'h0000_0005);
		bus(1'b1, `AFB_OFS_CTRL, 32'h0000_0007, 4'hf); chk({bsel, global_irq_gate}, 3'h7);
		bus(1'b0, `AFB_OFS_CTRL, 32'h0000_0000, 4'hf); chk(q, 32'h0000_0007);
		bus(1'b1, `AFB_OFS_CTRL, 32'h0000_0000, 4'hf);
		// Memory destination takes one more T-state; a shift never writes memory.
		ld(5'h01, 8'h40);
		exec(afb_pkg::AFB_OP_ADD, 5'h02, 5'h01, 8'h05, 1'b1, 1'b1, 3'h0, 2'h0, 2'h0);
		chk(lat, 2);
		chk({mw, md}, {1'b1, 8'h45});
		exec(afb_pkg::AFB_OP_SHL, 5'h02, 5'h02, 8'h00, 1'b1, 1'b1, 3'h1, 2'h0, 2'h0);
		chk(lat, 1);
		chk(mw, 1'b0);
		// Bank swap with every gate option; the hidden bank keeps its value.
		ld(5'h00, 8'h11);
		bus(1'b1, `AFB_OFS_FLAGS, 32'h0000_000a, 4'hf);
		exec(afb_pkg::AFB_OP_SWAP, 5'h00, 5'h00, 8'h00, 1'b0, 1'b0, 3'h0, 2'h1, 2'h2);
		chk({bsel, global_irq_gate, flg}, 7'h3a);
		getr(5'h00); chk(res, 8'h00);
		ld(5'h00, 8'h22);
		exec(afb_pkg::AFB_OP_SWAP, 5'h00, 5'h00, 8'h00, 1'b0, 1'b0, 3'h0, 2'h0, 2'h3);
		chk({bsel, global_irq_gate}, 3'h0);
		getr(5'h00); chk(res, 8'h11);
		exec(afb_pkg::AFB_OP_SWAP, 5'h00, 5'h00, 8'h00, 1'b0, 1'b0, 3'h0, 2'h2, 2'h0);
		chk({bsel, global_irq_gate}, 3'h4);
		getr(5'h00); chk(res, 8'h11);
		// Context push and pull; the gate bit of the pulled word is not used.
		bus(1'b1, `AFB_OFS_CTRL, 32'h0000_0006, 4'hf);
		bus(1'b1, `AFB_OFS_FLAGS, 32'h0000_0006, 4'hf);
		@(posedge clk);
		cs <= 1'b1;
		@(posedge clk);
		cs <= 1'b0;
		#1;
		chk({cso, cwo}, 8'he6);
		@(posedge clk);
		cr <= 1'b1;
		cw <= 7'h59;
		@(posedge clk);
		cr <= 1'b0;
		#1;
		chk({bsel, global_irq_gate, flg}, 7'h39);
		stop_test;
	end

endmodule // afb_alu_tb_top
